// file: common/quir_pkg.sv
// Constants, register map and state types for the quad UART host pin logic
// Overview of operation
// - Strobe-style bus: low third channel select enables channel C.
// - Read/write-signal bus: third channel select pin becomes a high channel address bit.
// - Strobe-style: low fourth select enables channel D; read/write style ignores it.
// - Read/write style: first channel interrupt is one active-low open-drain device interrupt.
// - Read/write style: second, third and fourth interrupt pins held at logic low.
// - Strobe-style: high interrupt-force input enables all four interrupt pins continuously.
// - Strobe-style: low interrupt-force lets each modem control bit 3 gate its pin.
// - Per-channel active-low transmitter-ready pin reflects transmit FIFO or holding status.
// - With DMA enabled, transmitter-ready pin carries the transmit DMA request.
// - Per-channel active-low receiver-ready pin reflects receive FIFO or holding status.
// - With DMA enabled, receiver-ready pin carries the receive DMA request.
// - Combined active-low transmitter-ready is wired-OR of the four channel pins.
// - Combined active-low receiver-ready is wired-OR of the four channel pins.
// - Transmit DMA request needs enhanced mode bit 2; receive needs bit 3.
// - DMA request stays high until terminal count or its FIFO level condition.
package quir_pkg;
    localparam int NCH = 4;
    localparam logic STYLE_STROBE = 1'b1;

    // Register byte offsets; channel n register sits at base + 4*n
    localparam logic [7:0] OFF_MODEM_CTRL_BASE = 8'h00;
    localparam logic [7:0] OFF_ENH_MODE_BASE = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    localparam logic [3:0] BANK_MODEM_CTRL = 4'h0;
    localparam logic [3:0] BANK_ENH_MODE = 4'h1;

    localparam int MODEM_IRQ_EN_BIT = 3;
    localparam int ENH_TX_DMA_BIT = 2;
    localparam int ENH_RX_DMA_BIT = 3;
    localparam logic [7:0] MODEM_CTRL_RESET = 8'h00;
    localparam logic [7:0] ENH_MODE_RESET = 8'h00;

    // Status word field positions
    localparam int ST_TX_PIN_LSB = 0;
    localparam int ST_RX_PIN_LSB = 4;
    localparam int ST_TX_REQ_LSB = 8;
    localparam int ST_RX_REQ_LSB = 12;
    localparam int ST_PEND_LSB = 16;
    localparam int ST_STYLE_BIT = 20;

    localparam logic [3:0] PIN_N_IDLE = 4'hF;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic {QUIR_REQ_IDLE, QUIR_REQ_ACTIVE} quir_req_state_t;
endpackage

// file: src/quir_dma_req.sv
// One DMA request line: set by FIFO status, held until its end condition
`timescale 1ns/1ps
module quir_dma_req import quir_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic set_cond,
    input wire logic clr_cond,
    output logic req
);
    typedef struct packed {
        quir_req_state_t state;
    } quir_req_regs_t;

    quir_req_regs_t s_r;
    quir_req_regs_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        case (s_r.state)
            QUIR_REQ_IDLE: begin
                if (enable && set_cond && !clr_cond) begin
                    s_nxt.state = QUIR_REQ_ACTIVE;
                end
            end
            QUIR_REQ_ACTIVE: begin
                // Held until terminal count or level condition, or DMA disabled
                if (clr_cond || !enable) begin
                    s_nxt.state = QUIR_REQ_IDLE;
                end
            end
            default: s_nxt.state = QUIR_REQ_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{state: QUIR_REQ_IDLE};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign req = (s_r.state == QUIR_REQ_ACTIVE);

    sequence s_raise;
        enable && set_cond && !clr_cond && !req;
    endsequence

    property p_req_raise;
        @(posedge clk) disable iff (!rst_n) s_raise |=> req;
    endproperty
    a_req_raise: assert property (p_req_raise)
        else $error("request not raised on enabled set");

    property p_req_hold;
        @(posedge clk) disable iff (!rst_n) req && enable && !clr_cond |=> req;
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped without end condition");

    property p_req_end;
        @(posedge clk) disable iff (!rst_n) req && clr_cond |=> !req;
    endproperty
    a_req_end: assert property (p_req_end)
        else $error("request held past end condition");

    property p_req_needs_en;
        @(posedge clk) disable iff (!rst_n) !enable |=> !req;
    endproperty
    a_req_needs_en: assert property (p_req_needs_en)
        else $error("request active while DMA disabled");
endmodule // quir_dma_req

// file: src/quir_ahb_regs.sv
// AHB-Lite slave holding the per-channel modem control and enhanced mode registers
`timescale 1ns/1ps
module quir_ahb_regs import quir_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] status_word,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [NCH-1:0] irq_en,
    output logic [NCH-1:0] tx_dma_en,
    output logic [NCH-1:0] rx_dma_en
);
    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic [NCH-1:0][7:0] modem_control_reg;
        logic [NCH-1:0][7:0] enhanced_mode_select_reg;
    } quir_bus_regs_t;

    quir_bus_regs_t s_r;
    quir_bus_regs_t s_nxt;
    logic take;

    function automatic logic [31:0] rd_word(input logic [7:0] a, input quir_bus_regs_t r,
                                            input logic [31:0] st);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a == OFF_STATUS) begin
            w = st;
        end else if (a[7:4] == BANK_MODEM_CTRL && a[1:0] == 2'h0) begin
            w = {24'h00_0000, r.modem_control_reg[a[3:2]]};
        end else if (a[7:4] == BANK_ENH_MODE && a[1:0] == 2'h0) begin
            w = {24'h00_0000, r.enhanced_mode_select_reg[a[3:2]]};
        end
        return w;
    endfunction

    // Whole-word transfers only; other sizes complete OKAY with no effect
    assign take = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;

    always_comb begin
        s_nxt = s_r;
        s_nxt.wr_pend = take && hwrite;
        s_nxt.wr_addr = haddr[7:0];
        if (s_r.wr_pend && s_r.wr_addr[1:0] == 2'h0) begin
            if (s_r.wr_addr[7:4] == BANK_MODEM_CTRL) begin
                s_nxt.modem_control_reg[s_r.wr_addr[3:2]] = hwdata[7:0];
            end else if (s_r.wr_addr[7:4] == BANK_ENH_MODE) begin
                s_nxt.enhanced_mode_select_reg[s_r.wr_addr[3:2]] = hwdata[7:0];
            end
        end
        // Read data taken from the post-write copy so back-to-back write-read is coherent
        if (take && !hwrite) begin
            s_nxt.rdata = rd_word(haddr[7:0], s_nxt, status_word);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r.wr_pend <= 1'b0;
            s_r.wr_addr <= 8'h00;
            s_r.rdata <= 32'h0000_0000;
            s_r.modem_control_reg <= {NCH{MODEM_CTRL_RESET}};
            s_r.enhanced_mode_select_reg <= {NCH{ENH_MODE_RESET}};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hrdata = s_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_bits
            assign irq_en[g] = s_r.modem_control_reg[g][MODEM_IRQ_EN_BIT];
            assign tx_dma_en[g] = s_r.enhanced_mode_select_reg[g][ENH_TX_DMA_BIT];
            assign rx_dma_en[g] = s_r.enhanced_mode_select_reg[g][ENH_RX_DMA_BIT];
        end
    endgenerate

    // Any channel: the index is the word address of the address phase two edges back
    property p_modem_ctrl_write;
        @(posedge hclk) disable iff (!hresetn)
            take && hwrite && haddr[7:4] == BANK_MODEM_CTRL && haddr[1:0] == 2'h0
            ##1 hready |=> irq_en[$past(haddr[3:2], 2)] == $past(hwdata[MODEM_IRQ_EN_BIT]);
    endproperty
    a_modem_ctrl_write: assert property (p_modem_ctrl_write)
        else $error("modem control write did not land");

    property p_enh_mode_write;
        @(posedge hclk) disable iff (!hresetn)
            take && hwrite && haddr[7:4] == BANK_ENH_MODE && haddr[1:0] == 2'h0
            ##1 hready |=> tx_dma_en[$past(haddr[3:2], 2)] == $past(hwdata[ENH_TX_DMA_BIT])
                && rx_dma_en[$past(haddr[3:2], 2)] == $past(hwdata[ENH_RX_DMA_BIT]);
    endproperty
    a_enh_mode_write: assert property (p_enh_mode_write)
        else $error("enhanced mode write did not land");
endmodule // quir_ahb_regs

// file: src/quir_host_pins.sv
// Host-side pin logic: channel select decode, interrupt pin gating, ready and DMA pins
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module quir_host_pins import quir_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic bus_style_sel,
    input wire logic third_channel_select_n,
    input wire logic fourth_channel_select_n,
    input wire logic irq_output_force,
    input wire logic dma_terminal_count,
    input wire logic [NCH-1:0] chan_irq_pending,
    input wire logic [NCH-1:0] tx_holding_ready,
    input wire logic [NCH-1:0] rx_holding_ready,
    input wire logic [NCH-1:0] tx_fifo_above_trigger,
    input wire logic [NCH-1:0] rx_fifo_empty,
    output logic third_channel_enable,
    output logic fourth_channel_enable,
    output logic high_channel_address_bit,
    output logic first_channel_irq_o,
    output logic first_channel_irq_oe,
    output logic second_channel_irq_o,
    output logic second_channel_irq_oe,
    output logic third_channel_irq_o,
    output logic third_channel_irq_oe,
    output logic fourth_channel_irq_o,
    output logic fourth_channel_irq_oe,
    output logic [NCH-1:0] per_channel_tx_ready_n,
    output logic [NCH-1:0] per_channel_rx_ready_n,
    output logic combined_tx_ready_n,
    output logic combined_rx_ready_n,
    output logic [NCH-1:0] tx_dma_request,
    output logic [NCH-1:0] rx_dma_request
);
    typedef struct packed {
        logic style;
        logic third_en;
        logic fourth_en;
        logic addr_bit;
        logic [NCH-1:0] irq_o;
        logic [NCH-1:0] irq_oe;
        logic [NCH-1:0] tx_n;
        logic [NCH-1:0] rx_n;
        logic tx_all_n;
        logic rx_all_n;
    } quir_pin_regs_t;

    quir_pin_regs_t s_r;
    quir_pin_regs_t s_nxt;
    logic [NCH-1:0] irq_en;
    logic [NCH-1:0] tx_dma_en;
    logic [NCH-1:0] rx_dma_en;
    logic [NCH-1:0] tx_req;
    logic [NCH-1:0] rx_req;
    logic [31:0] status_word;
    logic strobe;
    logic force_on;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ST_TX_PIN_LSB +: NCH] = s_r.tx_n;
        status_word[ST_RX_PIN_LSB +: NCH] = s_r.rx_n;
        status_word[ST_TX_REQ_LSB +: NCH] = tx_req;
        status_word[ST_RX_REQ_LSB +: NCH] = rx_req;
        status_word[ST_PEND_LSB +: NCH] = chan_irq_pending;
        status_word[ST_STYLE_BIT] = s_r.style;
    end

    quir_ahb_regs u_regs (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .status_word(status_word),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .irq_en(irq_en),
        .tx_dma_en(tx_dma_en),
        .rx_dma_en(rx_dma_en)
    );

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_dma
            // Transmit request ends on terminal count or FIFO filled past trigger
            quir_dma_req u_tx (
                .clk(hclk),
                .rst_n(hresetn),
                .enable(tx_dma_en[g]),
                .set_cond(tx_holding_ready[g]),
                .clr_cond(dma_terminal_count || tx_fifo_above_trigger[g]),
                .req(tx_req[g])
            );
            // Receive request ends on terminal count or FIFO emptied
            quir_dma_req u_rx (
                .clk(hclk),
                .rst_n(hresetn),
                .enable(rx_dma_en[g]),
                .set_cond(rx_holding_ready[g]),
                .clr_cond(dma_terminal_count || rx_fifo_empty[g]),
                .req(rx_req[g])
            );
        end
    endgenerate

    assign strobe = (bus_style_sel == STYLE_STROBE);
    // Force pin only has meaning on the strobe-style bus; ignored otherwise
    assign force_on = strobe && irq_output_force;

    always_comb begin
        s_nxt = s_r;
        // Pin roles follow the strap level; it is expected not to move in operation
        s_nxt.style = bus_style_sel;
        s_nxt.third_en = strobe && !third_channel_select_n;
        s_nxt.fourth_en = strobe && !fourth_channel_select_n;
        s_nxt.addr_bit = !strobe && third_channel_select_n;
        for (int i = 0; i < NCH; i++) begin
            if (strobe) begin
                s_nxt.irq_o[i] = chan_irq_pending[i];
                s_nxt.irq_oe[i] = force_on || irq_en[i];
            end else if (i == 0) begin
                // Open drain: only ever pulls low, released when nothing pends
                s_nxt.irq_o[i] = 1'b0;
                s_nxt.irq_oe[i] = |chan_irq_pending;
            end else begin
                s_nxt.irq_o[i] = 1'b0;
                s_nxt.irq_oe[i] = 1'b1;
            end
            // DMA mode turns the pin into an active-high request line
            s_nxt.tx_n[i] = tx_dma_en[i] ? tx_req[i] : !tx_holding_ready[i];
            s_nxt.rx_n[i] = rx_dma_en[i] ? rx_req[i] : !rx_holding_ready[i];
        end
        // Active-low wired-OR: any channel low drives the combined pin low
        s_nxt.tx_all_n = &s_nxt.tx_n;
        s_nxt.rx_all_n = &s_nxt.rx_n;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r.style <= STYLE_STROBE;
            s_r.third_en <= 1'b0;
            s_r.fourth_en <= 1'b0;
            s_r.addr_bit <= 1'b0;
            s_r.irq_o <= '0;
            s_r.irq_oe <= '0;
            s_r.tx_n <= PIN_N_IDLE;
            s_r.rx_n <= PIN_N_IDLE;
            s_r.tx_all_n <= 1'b1;
            s_r.rx_all_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign third_channel_enable = s_r.third_en;
    assign fourth_channel_enable = s_r.fourth_en;
    assign high_channel_address_bit = s_r.addr_bit;
    assign first_channel_irq_o = s_r.irq_o[0];
    assign first_channel_irq_oe = s_r.irq_oe[0];
    assign second_channel_irq_o = s_r.irq_o[1];
    assign second_channel_irq_oe = s_r.irq_oe[1];
    assign third_channel_irq_o = s_r.irq_o[2];
    assign third_channel_irq_oe = s_r.irq_oe[2];
    assign fourth_channel_irq_o = s_r.irq_o[3];
    assign fourth_channel_irq_oe = s_r.irq_oe[3];
    assign per_channel_tx_ready_n = s_r.tx_n;
    assign per_channel_rx_ready_n = s_r.rx_n;
    assign combined_tx_ready_n = s_r.tx_all_n;
    assign combined_rx_ready_n = s_r.rx_all_n;
    assign tx_dma_request = tx_req;
    assign rx_dma_request = rx_req;

    property p_sel_c;
        @(posedge hclk) disable iff (!hresetn)
            1'b1 |=> third_channel_enable == ($past(bus_style_sel) && !$past(third_channel_select_n));
    endproperty
    a_sel_c: assert property (p_sel_c)
        else $error("channel C enable wrong");

    property p_addr_bit;
        @(posedge hclk) disable iff (!hresetn)
            !bus_style_sel |=> high_channel_address_bit == $past(third_channel_select_n);
    endproperty
    a_addr_bit: assert property (p_addr_bit)
        else $error("high channel address bit wrong");

    property p_sel_d_ignored;
        @(posedge hclk) disable iff (!hresetn) !bus_style_sel |=> !fourth_channel_enable;
    endproperty
    a_sel_d_ignored: assert property (p_sel_d_ignored)
        else $error("channel D enabled in read/write mode");

    property p_force_all;
        @(posedge hclk) disable iff (!hresetn)
            bus_style_sel && irq_output_force |=> first_channel_irq_oe && second_channel_irq_oe
                && third_channel_irq_oe && fourth_channel_irq_oe;
    endproperty
    a_force_all: assert property (p_force_all)
        else $error("force did not enable all interrupt pins");

    property p_irq_gate;
        @(posedge hclk) disable iff (!hresetn)
            bus_style_sel && !irq_output_force |=> second_channel_irq_oe == $past(irq_en[1]);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt enable does not follow modem control bit");

    property p_od_irq;
        @(posedge hclk) disable iff (!hresetn)
            !bus_style_sel |=> !first_channel_irq_o && first_channel_irq_oe == $past(|chan_irq_pending);
    endproperty
    a_od_irq: assert property (p_od_irq)
        else $error("device interrupt not open drain active low");

    property p_unused_low;
        @(posedge hclk) disable iff (!hresetn)
            !bus_style_sel |=> fourth_channel_irq_oe && !fourth_channel_irq_o;
    endproperty
    a_unused_low: assert property (p_unused_low)
        else $error("unused interrupt pin not held low");

    property p_tx_pin;
        @(posedge hclk) disable iff (!hresetn)
            !tx_dma_en[0] |=> per_channel_tx_ready_n[0] == !$past(tx_holding_ready[0]);
    endproperty
    a_tx_pin: assert property (p_tx_pin)
        else $error("transmit ready pin wrong");

    property p_rx_dma_pin;
        @(posedge hclk) disable iff (!hresetn)
            rx_dma_en[1] |=> per_channel_rx_ready_n[1] == $past(rx_req[1]);
    endproperty
    a_rx_dma_pin: assert property (p_rx_dma_pin)
        else $error("receive pin not carrying DMA request");

    property p_combined;
        @(posedge hclk) disable iff (!hresetn)
            combined_tx_ready_n == &per_channel_tx_ready_n
                && combined_rx_ready_n == &per_channel_rx_ready_n;
    endproperty
    a_combined: assert property (p_combined)
        else $error("combined ready pins disagree with channel pins");
endmodule // quir_host_pins

// file: tb/quir_dma_host.sv
// DMA controller model that ends pending DMA requests with a terminal-count pulse
`timescale 1ns/1ps
module quir_dma_host import quir_pkg::*; #(
    parameter int LAT = 3
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic serve,
    input wire logic [NCH-1:0] tx_req,
    input wire logic [NCH-1:0] rx_req,
    output logic dma_terminal_count
);
    int wait_r;
    // A slow controller: a request stands LAT+1 served cycles before terminal count is pulsed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_r <= 0;
            dma_terminal_count <= 1'b0;
        end else begin
            dma_terminal_count <= 1'b0;
            if (serve && (|tx_req || |rx_req) && !dma_terminal_count) begin
                wait_r <= wait_r + 1;
                if (wait_r == LAT) begin
                    wait_r <= 0;
                    dma_terminal_count <= 1'b1;
                end
            end else begin
                wait_r <= 0;
            end
        end
    end
endmodule // quir_dma_host

// file: tb/test_quad_uart_host_select_irq_ready.sv
// Self-checking bench for the quad UART host pin logic
`timescale 1ns/1ps
module test_quad_uart_host_select_irq_ready import quir_pkg::*;;
    typedef struct packed {
        logic [3:0] mode, m, p, t, r;
        logic [2:0] en;
        logic pad;
        logic [3:0] oe, o, tn, rn;
    } quir_row_t;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic style, third_sel_n, fourth_sel_n, irq_force, term_count, serve, cen, den, abit, ctx, crx;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] pend, txh, rxh, trig, empty, irq_oe, irq_o, txn, rxn, txq, rxq;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    quir_row_t rows [6];
    quir_row_t w;
    assign hready = hreadyout;

    quir_host_pins quir_host_pins_i (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
        .hrdata, .hreadyout, .hresp, .bus_style_sel(style),
        .third_channel_select_n(third_sel_n), .fourth_channel_select_n(fourth_sel_n),
        .irq_output_force(irq_force), .dma_terminal_count(term_count), .chan_irq_pending(pend),
        .tx_holding_ready(txh), .rx_holding_ready(rxh), .tx_fifo_above_trigger(trig),
        .rx_fifo_empty(empty), .third_channel_enable(cen), .fourth_channel_enable(den),
        .high_channel_address_bit(abit),
        .first_channel_irq_o(irq_o[0]), .first_channel_irq_oe(irq_oe[0]),
        .second_channel_irq_o(irq_o[1]), .second_channel_irq_oe(irq_oe[1]),
        .third_channel_irq_o(irq_o[2]), .third_channel_irq_oe(irq_oe[2]),
        .fourth_channel_irq_o(irq_o[3]), .fourth_channel_irq_oe(irq_oe[3]),
        .per_channel_tx_ready_n(txn), .per_channel_rx_ready_n(rxn),
        .combined_tx_ready_n(ctx), .combined_rx_ready_n(crx),
        .tx_dma_request(txq), .rx_dma_request(rxq)
    );

    quir_dma_host quir_dma_host_i (
        .hclk, .hresetn, .serve, .tx_req(txq), .rx_req(rxq), .dma_terminal_count(term_count)
    );

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // A hang in a bus wait ends here as a mismatch; the DMA wait loop gives up by itself after 20 cycles
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            results();
        end
    end

    task automatic chk_pin(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_bus(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    // Single word transfer; waits on hready in both phases, data taken at the last edge
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge hclk);
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        hsize <= HSIZE_WORD;
        hsel <= 1'b1;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, irq_force, serve} = 4'h0;
        {style, third_sel_n, fourth_sel_n} = 3'h7;
        {haddr, hwdata} = 64'h0;
        htrans = 2'h0;
        hsize = HSIZE_WORD;
        {pend, txh, rxh, trig} = 16'h0;
        empty = 4'hF;
        // mode = style, third select, fourth select, force
        rows[0] = 40'hA_0F00_8_00FF;
        rows[1] = 40'hC_5318_4_51E7;
        rows[2] = 40'hF_0AFF_0_FA00;
        rows[3] = 40'h8_8842_C_88BD;
        rows[4] = 40'h4_F000_2_E0FF;
        rows[5] = 40'h2_0435_0_F0CA;
        repeat (4) @(posedge hclk);
        @(negedge hclk);
        chk_pin("reset_oe", 8'h00, {irq_oe, txq});
        chk_pin("reset_ready", 8'hFF, {txn, rxn});
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        bus(8'h00, 1'b0, 32'h0, rd);
        chk_bus("modem_ctrl_reset", 32'h0, rd);
        bus(8'h04, 1'b1, 32'hFFFFFFFF, rd);
        bus(8'h04, 1'b0, 32'h0, rd);
        chk_bus("modem_ctrl_rw", 32'h000000FF, rd);
        bus(8'h1C, 1'b1, 32'hFFFFFF03, rd);
        bus(8'h1C, 1'b0, 32'h0, rd);
        chk_bus("enh_mode_rw", 32'h00000003, rd);
        bus(8'h40, 1'b1, 32'h1234ABCD, rd);
        bus(8'h40, 1'b0, 32'h0, rd);
        chk_bus("unmapped", 32'h0, rd);
        foreach (rows[i]) begin
            w = rows[i];
            for (int c = 0; c < 4; c++) begin
                bus(8'(4 * c), 1'b1, {28'h0, w.m[c], 3'h0}, rd);
            end
            @(posedge hclk);
            {style, third_sel_n, fourth_sel_n, irq_force} <= w.mode;
            pend <= w.p;
            txh <= w.t;
            rxh <= w.r;
            @(posedge hclk);
            @(negedge hclk);
            chk_pin("select", {5'h0, w.en}, {5'h0, cen, den, abit});
            chk_pin("irq_oe", {4'h0, w.oe}, {4'h0, irq_oe});
            chk_pin("irq_val", {4'h0, w.o}, {4'h0, irq_o & irq_oe});
            chk_pin("ready", {w.tn, w.rn}, {txn, rxn});
            chk_pin("combined", {6'h0, &w.tn, &w.rn}, {6'h0, ctx, crx});
        end
        bus(8'h18, 1'b1, 32'h00000004, rd);
        bus(8'h14, 1'b1, 32'h00000008, rd);
        @(posedge hclk);
        {pend, rxh, txh} <= 12'h037;
        empty <= 4'hD;
        @(posedge hclk);
        @(negedge hclk);
        chk_pin("dma_req", 8'h42, {txq, rxq});
        @(posedge hclk);
        txh <= 4'h0;
        @(negedge hclk);
        chk_pin("dma_pins", 8'hCE, {txn, rxn});
        chk_pin("dma_combined", 8'h00, {6'h0, ctx, crx});
        repeat (4) @(posedge hclk);
        @(negedge hclk);
        chk_pin("dma_hold", 8'h42, {txq, rxq});
        // Status word: requests tx 4 rx 2, pins tx F rx E, nothing pending, read/write style
        bus(8'h20, 1'b0, 32'h0, rd);
        chk_bus("status", 32'h000024EF, rd);
        chk_bus("hresp", 32'h0, {31'h0, hresp});
        @(posedge hclk);
        serve <= 1'b1;
        rxh <= 4'h0;
        for (int k = 0; k < 20 && txq !== 4'h0; k++) begin
            @(negedge hclk);
        end
        chk_pin("dma_tc", 8'h00, {txq, rxq});
        @(negedge hclk);
        chk_pin("dma_idle_pins", 8'hBD, {txn, rxn});
        @(posedge hclk);
        serve <= 1'b0;
        txh <= 4'h4;
        rxh <= 4'h2;
        @(posedge hclk);
        @(negedge hclk);
        chk_pin("dma_again", 8'h42, {txq, rxq});
        @(posedge hclk);
        // Holding status stays up, so the end condition has to win
        trig <= 4'h4;
        empty <= 4'hF;
        @(posedge hclk);
        @(negedge hclk);
        chk_pin("dma_end", 8'h00, {txq, rxq});
        results();
    end
endmodule // test_quad_uart_host_select_irq_ready
